// [rtl/sgc_pkg.sv]
// constants for the global forwarding and host link control bank
package sgc_pkg;

  localparam logic [7:0] SGC_FWD_CTRL_ADDR  = 8'h05;
  localparam logic [7:0] SGC_HOST_LINK_ADDR = 8'h06;

  localparam logic [7:0] SGC_FWD_CTRL_RESET  = 8'h00;
  localparam logic [7:0] SGC_HOST_LINK_RESET = 8'h00;
  localparam logic [7:0] SGC_FWD_CTRL_WMASK  = 8'hf3;
  localparam logic [7:0] SGC_HOST_LINK_WMASK = 8'he0;
  localparam logic [7:0] SGC_UNMAPPED_DATA   = 8'h00;

  localparam int SGC_VLAN_EN_BIT   = 7;
  localparam int SGC_IGMP_SNP_BIT  = 6;
  localparam int SGC_DIRECT_BIT    = 5;
  localparam int SGC_PRETAG_BIT    = 4;
  localparam int SGC_TAG_MASK_BIT  = 1;
  localparam int SGC_SNIFF_AND_BIT = 0;

  localparam int SGC_BACK_PRES_BIT = 7;
  localparam int SGC_HALF_DUP_BIT  = 6;
  localparam int SGC_FLOW_CTL_BIT  = 5;

  localparam int SGC_PORTS         = 5;
  localparam int SGC_HOST_PORT     = 4;
  localparam int SGC_SRC_PORT_W    = 3;
  localparam int SGC_VID_W         = 12;

  localparam int SGC_STRAP_DUPLEX  = 0;
  localparam int SGC_STRAP_FLOW    = 1;
  localparam int SGC_STRAP_W       = 2;

  typedef enum logic {
    SGC_PH_RESET = 1'b0,
    SGC_PH_RUN   = 1'b1
  } sgc_phase_t;

endpackage : sgc_pkg

// [rtl/sgc_strap_sync.sv]
// two-flop synchroniser for the strap pins
`timescale 1ns/1ns
`default_nettype none

module sgc_strap_sync (
  input  wire logic                          clk,
  input  wire logic [sgc_pkg::SGC_STRAP_W-1:0] strap_pins,
  output var  logic [sgc_pkg::SGC_STRAP_W-1:0] strap_sync
);

  typedef struct packed {
    logic [sgc_pkg::SGC_STRAP_W-1:0] stage1;
    logic [sgc_pkg::SGC_STRAP_W-1:0] stage2;
  } sgc_sync_t;

  sgc_sync_t sync_q;
  sgc_sync_t sync_d;

  // no reset: the chain must already carry the pin level at reset release
  always_comb begin
    sync_d        = sync_q;
    sync_d.stage1 = strap_pins;
    sync_d.stage2 = sync_q.stage1;
  end

  always_ff @(posedge clk) begin
    sync_q <= sync_d;
  end

  assign strap_sync = sync_q.stage2;

endmodule : sgc_strap_sync

`default_nettype wire

// [rtl/sgc_global_ctrl.sv]
// global forwarding and host link control registers with decisions
`timescale 1ns/1ns
`default_nettype none

module sgc_global_ctrl (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [7:0]                         reg_wdata,
  output var  logic [7:0]                         reg_rdata,
  output var  logic                               reg_rdata_valid,
  input  wire logic                               duplex_strap_pin,
  input  wire logic                               flow_control_strap_pin,
  input  wire logic                               pkt_valid,
  input  wire logic                               pkt_is_igmp,
  input  wire logic                               pkt_from_host,
  input  wire logic [sgc_pkg::SGC_SRC_PORT_W-1:0] pkt_source_port,
  input  wire logic [sgc_pkg::SGC_VID_W-1:0]      vlan_identifier,
  input  wire logic [sgc_pkg::SGC_PORTS-1:0]      lookup_port_mask,
  input  wire logic [sgc_pkg::SGC_PORTS-1:0]      preamble_dest_mask,
  input  wire logic                               sniff_src_match,
  input  wire logic                               sniff_dst_match,
  output var  logic                               vlan_mode_en,
  output var  logic                               igmp_snoop_en,
  output var  logic                               direct_mode_en,
  output var  logic                               pretag_en,
  output var  logic                               tag_mask_active,
  output var  logic                               sniff_and_mode,
  output var  logic                               back_pressure_en,
  output var  logic                               half_duplex_mode,
  output var  logic                               flow_control_en,
  output var  logic                               egress_valid,
  output var  logic [sgc_pkg::SGC_PORTS-1:0]      egress_port_mask,
  output var  logic                               pretag_insert,
  output var  logic [sgc_pkg::SGC_SRC_PORT_W-1:0] pretag_port,
  output var  logic                               mirror_hit
);

  typedef struct packed {
    sgc_pkg::sgc_phase_t                 phase;
    logic [7:0]                          fwd;
    logic [7:0]                          link;
    logic                                tag_act;
    logic [7:0]                          rdata;
    logic                                rvalid;
    logic                                evalid;
    logic [sgc_pkg::SGC_PORTS-1:0]       emask;
    logic                                ptag;
    logic [sgc_pkg::SGC_SRC_PORT_W-1:0]  pport;
    logic                                mirror;
  } sgc_state_t;

  sgc_state_t st_q;
  sgc_state_t st_d;

  logic [sgc_pkg::SGC_STRAP_W-1:0] strap_sync;

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser

  sgc_strap_sync u_strap (
    .clk        (clk),
    .strap_pins ({flow_control_strap_pin, duplex_strap_pin}),
    .strap_sync (strap_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    st_d.evalid = 1'b0;
    if (rst) begin
      st_d.phase  = sgc_pkg::SGC_PH_RESET;
      st_d.fwd    = sgc_pkg::SGC_FWD_CTRL_RESET;
      st_d.link   = sgc_pkg::SGC_HOST_LINK_RESET;
      st_d.rdata  = 8'h00;
      st_d.emask  = '0;
      st_d.ptag   = 1'b0;
      st_d.pport  = '0;
      st_d.mirror = 1'b0;
    end else if (st_q.phase == sgc_pkg::SGC_PH_RESET) begin
      // strap capture on first edge after release
      st_d.phase = sgc_pkg::SGC_PH_RUN;
      st_d.link[sgc_pkg::SGC_HALF_DUP_BIT] =
        strap_sync[sgc_pkg::SGC_STRAP_DUPLEX];
      st_d.link[sgc_pkg::SGC_FLOW_CTL_BIT] =
        strap_sync[sgc_pkg::SGC_STRAP_FLOW];
    end else begin
      if (reg_wr && reg_addr == sgc_pkg::SGC_FWD_CTRL_ADDR) begin
        st_d.fwd = reg_wdata & sgc_pkg::SGC_FWD_CTRL_WMASK;
      end
      if (reg_wr && reg_addr == sgc_pkg::SGC_HOST_LINK_ADDR) begin
        st_d.link = reg_wdata & sgc_pkg::SGC_HOST_LINK_WMASK;
      end
      if (reg_rd) begin
        st_d.rvalid = 1'b1;
        case (reg_addr)
          sgc_pkg::SGC_FWD_CTRL_ADDR:  st_d.rdata = st_q.fwd;
          sgc_pkg::SGC_HOST_LINK_ADDR: st_d.rdata = st_q.link;
          default:                     st_d.rdata = sgc_pkg::SGC_UNMAPPED_DATA;
        endcase
      end
      if (pkt_valid) begin
        st_d.evalid = 1'b1;
        if (st_q.fwd[sgc_pkg::SGC_DIRECT_BIT] && pkt_from_host) begin
          st_d.emask = preamble_dest_mask;
        end else if (st_q.tag_act) begin
          st_d.emask = vlan_identifier[sgc_pkg::SGC_PORTS-1:0];
        end else begin
          st_d.emask = lookup_port_mask;
        end
        if (st_q.fwd[sgc_pkg::SGC_IGMP_SNP_BIT] && pkt_is_igmp) begin
          st_d.emask[sgc_pkg::SGC_HOST_PORT] = 1'b1;
        end
        st_d.ptag  = st_q.fwd[sgc_pkg::SGC_PRETAG_BIT] &&
                     st_d.emask[sgc_pkg::SGC_HOST_PORT];
        st_d.pport = pkt_source_port;
        if (st_q.fwd[sgc_pkg::SGC_SNIFF_AND_BIT]) begin
          st_d.mirror = sniff_src_match && sniff_dst_match;
        end else begin
          st_d.mirror = sniff_src_match || sniff_dst_match;
        end
      end
    end
    // tag mask only while VLAN mode is off
    st_d.tag_act = st_d.fwd[sgc_pkg::SGC_TAG_MASK_BIT] &&
                   !st_d.fwd[sgc_pkg::SGC_VLAN_EN_BIT];
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata        = st_q.rdata;
  assign reg_rdata_valid  = st_q.rvalid;
  assign vlan_mode_en     = st_q.fwd[sgc_pkg::SGC_VLAN_EN_BIT];
  assign igmp_snoop_en    = st_q.fwd[sgc_pkg::SGC_IGMP_SNP_BIT];
  assign direct_mode_en   = st_q.fwd[sgc_pkg::SGC_DIRECT_BIT];
  assign pretag_en        = st_q.fwd[sgc_pkg::SGC_PRETAG_BIT];
  assign tag_mask_active  = st_q.tag_act;
  assign sniff_and_mode   = st_q.fwd[sgc_pkg::SGC_SNIFF_AND_BIT];
  assign back_pressure_en = st_q.link[sgc_pkg::SGC_BACK_PRES_BIT];
  assign half_duplex_mode = st_q.link[sgc_pkg::SGC_HALF_DUP_BIT];
  assign flow_control_en  = st_q.link[sgc_pkg::SGC_FLOW_CTL_BIT];
  assign egress_valid     = st_q.evalid;
  assign egress_port_mask = st_q.emask;
  assign pretag_insert    = st_q.ptag;
  assign pretag_port      = st_q.pport;
  assign mirror_hit       = st_q.mirror;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic running;
  assign running = (st_q.phase == sgc_pkg::SGC_PH_RUN);

  sequence fwd_write_s;
    running && reg_wr && reg_addr == sgc_pkg::SGC_FWD_CTRL_ADDR;
  endsequence

  sequence link_write_s;
    running && reg_wr && reg_addr == sgc_pkg::SGC_HOST_LINK_ADDR;
  endsequence

  sequence plain_pkt_s;
    running && pkt_valid && !(direct_mode_en && pkt_from_host);
  endsequence

  vlan_write_a: assert property (fwd_write_s |=>
    vlan_mode_en == $past(reg_wdata[sgc_pkg::SGC_VLAN_EN_BIT]))
    else $error("vlan enable not taken from write");

  tag_blocked_a: assert property (fwd_write_s ##0
    reg_wdata[sgc_pkg::SGC_VLAN_EN_BIT] |=> !tag_mask_active)
    else $error("tag mask active with vlan mode on");

  reserved_read_a: assert property (running && reg_rd &&
    reg_addr == sgc_pkg::SGC_FWD_CTRL_ADDR |=>
    reg_rdata_valid &&
    (reg_rdata & ~sgc_pkg::SGC_FWD_CTRL_WMASK) == 8'h00 &&
    reg_rdata == $past(st_q.fwd))
    else $error("forwarding readback wrong");

  link_write_a: assert property (link_write_s |=>
    back_pressure_en == $past(reg_wdata[sgc_pkg::SGC_BACK_PRES_BIT]) &&
    half_duplex_mode == $past(reg_wdata[sgc_pkg::SGC_HALF_DUP_BIT]) &&
    flow_control_en == $past(reg_wdata[sgc_pkg::SGC_FLOW_CTL_BIT]))
    else $error("host link bits not taken from write");

  strap_load_a: assert property (!running && !rst |=>
    half_duplex_mode == $past(strap_sync[sgc_pkg::SGC_STRAP_DUPLEX]) &&
    flow_control_en == $past(strap_sync[sgc_pkg::SGC_STRAP_FLOW]) &&
    running)
    else $error("strap value not captured at release");

  igmp_host_a: assert property (running && pkt_valid && pkt_is_igmp &&
    igmp_snoop_en |=> egress_valid &&
    egress_port_mask[sgc_pkg::SGC_HOST_PORT])
    else $error("igmp packet not sent to host port");

  direct_dest_a: assert property (running && pkt_valid &&
    direct_mode_en && pkt_from_host && !pkt_is_igmp |=>
    egress_port_mask == $past(preamble_dest_mask))
    else $error("direct mode destination wrong");

  tag_mask_a: assert property (plain_pkt_s ##0 tag_mask_active &&
    !pkt_is_igmp |=>
    egress_port_mask == $past(vlan_identifier[sgc_pkg::SGC_PORTS-1:0]))
    else $error("tag mask destination wrong");

  pretag_a: assert property (running && pkt_valid && pretag_en &&
    pkt_is_igmp && igmp_snoop_en |=> pretag_insert &&
    pretag_port == $past(pkt_source_port))
    else $error("host-bound packet not pre-tagged");

  sniff_and_a: assert property (running && pkt_valid &&
    sniff_and_mode |=> mirror_hit ==
    ($past(sniff_src_match) && $past(sniff_dst_match)))
    else $error("and-sniff decision wrong");

  sniff_or_a: assert property (running && pkt_valid &&
    !sniff_and_mode |=> mirror_hit ==
    ($past(sniff_src_match) || $past(sniff_dst_match)))
    else $error("or-sniff decision wrong");

endmodule : sgc_global_ctrl

`default_nettype wire

// [verification/sgc_host_mac.sv]
// host mac stand-in driving the preamble side of packets
`timescale 1ns/1ns
`default_nettype none

module sgc_host_mac (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] dest,
  output var  logic       from_host,
  output var  logic [4:0] pre_mask
);
  logic [4:0] last_q = 5'h00;

  // preamble in the same cycle as data valid names the destination
  always_comb begin
    from_host = go;
    pre_mask  = go ? dest : ~last_q;
  end

  always_ff @(posedge clk) begin
    if (go) begin
      last_q <= dest;
    end
  end
endmodule : sgc_host_mac

`default_nettype wire

// [verification/sgc_global_ctrl_tb_top.sv]
// self-checking bench for the global control register bank
`timescale 1ns/1ns
`default_nettype none

module sgc_global_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        duplex_strap_pin = 1'b0;
  logic        flow_control_strap_pin = 1'b0;
  logic        pkt_valid = 1'b0;
  logic        pkt_is_igmp = 1'b0;
  logic        h_go = 1'b0;
  logic [2:0]  pkt_source_port = 3'h0;
  logic [11:0] vlan_identifier = 12'h000;
  logic [4:0]  lookup_port_mask = 5'h00;
  logic [4:0]  h_dest = 5'h00;
  logic        sniff_src_match = 1'b0;
  logic        sniff_dst_match = 1'b0;
  logic        pkt_from_host;
  logic [4:0]  preamble_dest_mask;
  logic [7:0]  reg_rdata;
  logic        reg_rdata_valid, vlan_mode_en, igmp_snoop_en, direct_mode_en;
  logic        pretag_en, tag_mask_active, sniff_and_mode, back_pressure_en;
  logic        half_duplex_mode, flow_control_en, egress_valid;
  logic        pretag_insert, mirror_hit;
  logic [4:0]  egress_port_mask;
  logic [2:0]  pretag_port;
  logic [7:0]  fwd_lv, link_lv, pkt_lv;
  int          err_total = 0;
  int          checks = 0;

  assign fwd_lv = {vlan_mode_en, igmp_snoop_en, direct_mode_en, pretag_en,
                   2'h0, tag_mask_active, sniff_and_mode};
  assign link_lv = {back_pressure_en, half_duplex_mode, flow_control_en,
                    5'h00};
  assign pkt_lv = {egress_valid, mirror_hit, pretag_insert, 5'h00};

  sgc_global_ctrl dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rdata_valid, .duplex_strap_pin, .flow_control_strap_pin,
    .pkt_valid, .pkt_is_igmp, .pkt_from_host, .pkt_source_port,
    .vlan_identifier, .lookup_port_mask, .preamble_dest_mask,
    .sniff_src_match, .sniff_dst_match, .vlan_mode_en, .igmp_snoop_en,
    .direct_mode_en, .pretag_en, .tag_mask_active, .sniff_and_mode,
    .back_pressure_en, .half_duplex_mode, .flow_control_en, .egress_valid,
    .egress_port_mask, .pretag_insert, .pretag_port, .mirror_hit);

  sgc_host_mac host (.clk, .go(h_go), .dest(h_dest),
    .from_host(pkt_from_host), .pre_mask(preamble_dest_mask));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rdata_valid}, 8'h01);
    chk(reg_rdata, e);
  endtask : rd

  // f = {igmp, from host, src match, dst match, 0, source port}
  task automatic pkt(input logic [7:0] f, input logic [4:0] lk,
                     input logic [4:0] em, input logic [7:0] ef);
    @(posedge clk);
    pkt_valid <= 1'b1;
    {pkt_is_igmp, h_go, sniff_src_match, sniff_dst_match} <= f[7:4];
    pkt_source_port <= f[2:0];
    vlan_identifier <= 12'h3ea;
    lookup_port_mask <= lk;
    h_dest <= 5'h06;
    @(posedge clk);
    pkt_valid <= 1'b0;
    h_go <= 1'b0;
    #1;
    chk({3'h0, egress_port_mask}, {3'h0, em});
    chk(pkt_lv, ef);
  endtask : pkt

  ////////////////////////////////////////////////////////////////////////////
  task automatic rst_run(input logic d, input logic f, input logic [7:0] e);
    @(posedge clk);
    rst <= 1'b1;
    duplex_strap_pin <= d;
    flow_control_strap_pin <= f;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(link_lv, e);
    $display("test reset done");
  endtask : rst_run

  task automatic t_regs;
    wr(8'h05, 8'hff);
    chk(fwd_lv, 8'hf1);
    rd(8'h05, 8'hf3);
    wr(8'h06, 8'hff);
    chk(link_lv, 8'he0);
    rd(8'h06, 8'he0);
    wr(8'h06, 8'h00);
    chk(link_lv, 8'h00);
    rd(8'h07, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_fwd;
    wr(8'h05, 8'h02);
    chk(fwd_lv, 8'h02);
    pkt(8'h02, 5'h01, 5'h0a, 8'h80);
    wr(8'h05, 8'h82);
    pkt(8'h02, 5'h01, 5'h01, 8'h80);
    wr(8'h05, 8'h20);
    pkt(8'h40, 5'h01, 5'h06, 8'h80);
    pkt(8'h00, 5'h01, 5'h01, 8'h80);
    wr(8'h05, 8'h50);
    pkt(8'h83, 5'h01, 5'h11, 8'ha0);
    chk({5'h00, pretag_port}, 8'h03);
    pkt(8'h03, 5'h01, 5'h01, 8'h80);
    wr(8'h05, 8'h01);
    pkt(8'h20, 5'h01, 5'h01, 8'h80);
    pkt(8'h30, 5'h01, 5'h01, 8'hc0);
    wr(8'h05, 8'h00);
    pkt(8'h90, 5'h01, 5'h01, 8'hc0);
    pkt(8'h10, 5'h01, 5'h01, 8'hc0);
    pkt(8'h00, 5'h01, 5'h01, 8'h80);
    $display("test forwarding done");
  endtask : t_fwd

  task automatic end_of_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_run(1'b1, 1'b0, 8'h40);
    rd(8'h06, 8'h40);
    t_regs();
    rst_run(1'b0, 1'b1, 8'h20);
    rd(8'h05, 8'h00);
    t_fwd();
    end_of_test();
  end

  initial begin
    #(2000 * 100);
    err_total++;
    end_of_test();
  end
endmodule : sgc_global_ctrl_tb_top

`default_nettype wire
